// ===== verilog/alu_consts.svh
// constants for the signed arithmetic and loop branch datapath
// assumes 32-bit operands and 9-bit branch addresses
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH
`define OP_SIGNED_ADD 6'h34
`define OP_SIGNED_SUBTRACT 6'h35
`define OP_SIGNED_ADD_WITH_CARRY 6'h36
`define OP_SIGNED_SUBTRACT_WITH_BORROW 6'h37
`define OP_CONDITIONAL_SUBTRACT 6'h38
`define OP_DECREMENT_BRANCH_NONZERO 6'h39
`define OP_TEST_BRANCH_NONZERO 6'h3a
`define OP_TEST_BRANCH_ZERO 6'h3b
`define DATA_W 32
`define ADDR_W 9
`define NORMAL_CLOCKS 4
`define NO_BRANCH_CLOCKS 8
`endif

// ===== verilog/alu_pkg.sv
// types for the signed arithmetic and loop branch datapath
// includes alu_consts.svh itself for the widths
`include "alu_consts.svh"
package alu_pkg;
  typedef struct packed {
    logic [5:0] opcode;
    logic [`DATA_W-1:0] dst;
    logic [`DATA_W-1:0] src;
    logic zero_in;
    logic carry_in;
  } op_req_t;
  typedef struct packed {
    logic [`DATA_W-1:0] result;
    logic write_back;
    logic zero;
    logic carry;
    logic branch;
    logic [`ADDR_W-1:0] target;
  } op_res_t;
endpackage : alu_pkg

// ===== verilog/op_timer.sv
// cycle counter that pulses done once the instruction time elapses
// assumes start arrives only while idle
`include "alu_consts.svh"
module op_timer (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [3:0] cycles_i,
  output logic busy_o,
  output logic done_o
);
  logic [3:0] count;
  logic [3:0] next_count;
  logic done;
  logic next_done;

  // load on start, count down, pulse done at the last cycle
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (start_i && count == 4'h0) begin
      next_count = cycles_i - 4'h1;
    end else if (count != 4'h0) begin
      next_count = count - 4'h1;
      next_done = (count == 4'h1);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= 4'h0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end

  assign busy_o = (count != 4'h0);
  assign done_o = done;
endmodule : op_timer

// ===== verilog/arith_branch_unit.sv
// execution slice: signed add/sub, conditional subtract, loop branches
// assumes the decoder holds req_i stable only for the start cycle
// Function
// RULE1: signed_subtract writes D-S, zero on zero result, carry on overflow.
// RULE2: signed_add_with_carry writes D+S+C, zero is old Z and zero sum.
// RULE3: signed_subtract_with_borrow writes D-(S+C), zero is old Z and zero.
// RULE4: conditional_subtract writes D-S only if D>=S unsigned, Z on equal.
// RULE5: decrement_branch_nonzero decrements D, branches if nonzero, 8 clk; the code takes 8 clk only on loop exit and 4 clk when it branches.
// RULE6: test_branch_nonzero branches if D nonzero, no write, carry clear.
// RULE7: test_branch_zero branches if D zero, no write, carry clear.
// RULE8: signed_add writes D+S, zero on zero sum, carry on overflow.
`include "alu_consts.svh"
module arith_branch_unit (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire alu_pkg::op_req_t req_i,
  output logic busy_o,
  output logic done_o,
  output alu_pkg::op_res_t res_o
);
  localparam int W = `DATA_W;
  localparam int AW = `ADDR_W;

  // registered result and the value it takes at the next edge
  alu_pkg::op_res_t res;
  alu_pkg::op_res_t next_res;
  // outcome of the instruction on the request lines
  alu_pkg::op_res_t op_res;
  logic [W-1:0] op_result;
  logic op_write;
  logic op_zero;
  logic op_carry;
  logic op_branch;
  logic long_path;
  // timer side
  logic [3:0] cycles;
  logic busy;
  logic taken;
  // operand views and arithmetic
  logic [W-1:0] d;
  logic [W-1:0] s;
  logic [W-1:0] cin;
  logic [W-1:0] sum;
  logic [W-1:0] diff;
  logic [W-1:0] sumc;
  logic [W-1:0] diffc;
  logic [W:0] wide;
  logic d_sign;
  logic s_sign;
  logic ovf_add;
  logic ovf_sub;
  logic ovf_addc;
  logic ovf_subc;
  logic d_zero;
  logic d_eq_s;
  logic d_ge_s;
  logic dec_zero;
  logic dec_borrow;

  // operand views; the carry flag joins as a one-bit addend
  assign d = req_i.dst;
  assign s = req_i.src;
  assign cin = {{(W-1){1'b0}}, req_i.carry_in};
  assign d_sign = d[W-1];
  assign s_sign = s[W-1];

  // plain and carry-extended sums and differences
  assign sum = d + s;
  assign diff = d - s;
  assign sumc = d + s + cin;
  assign diffc = d - s - cin;

  // decrement one bit wider so the borrow out of zero is visible
  assign wide = {1'b0, d} - {{W{1'b0}}, 1'b1};
  assign dec_zero = (wide[W-1:0] == '0);
  assign dec_borrow = wide[W];

  // operand compares for the conditional subtract and the tests
  assign d_zero = (d == '0);
  assign d_eq_s = (d == s);
  assign d_ge_s = (d >= s);

  // signed overflow: the result leaves the destination's sign while
  // the operands agree (add) or differ (subtract) in sign; the
  // carry-in stays out of the sign test, a known limitation
  assign ovf_add = (d_sign == s_sign) && (sum[W-1] != d_sign);
  assign ovf_sub = (d_sign != s_sign) && (diff[W-1] != d_sign);
  assign ovf_addc = (d_sign == s_sign) && (sumc[W-1] != d_sign);
  assign ovf_subc = (d_sign != s_sign) && (diffc[W-1] != d_sign);

  // a request counts only while the timer is idle; one that comes
  // while busy is dropped without notice, so the decoder must wait
  assign taken = start_i && !busy;

  // value and write-back for each instruction of the slice
  always_comb begin
    op_result = d;
    op_write = 1'b1;
    unique case (req_i.opcode)
      // RULE8 signed sum
      `OP_SIGNED_ADD: op_result = sum;
      // RULE1 signed difference
      `OP_SIGNED_SUBTRACT: op_result = diff;
      // RULE2 sum with carry
      `OP_SIGNED_ADD_WITH_CARRY: op_result = sumc;
      // RULE3 difference with borrow
      `OP_SIGNED_SUBTRACT_WITH_BORROW: op_result = diffc;
      // RULE4 subtract only when it fits
      `OP_CONDITIONAL_SUBTRACT: op_result = d_ge_s ? diff : d;
      // RULE5 decremented count
      `OP_DECREMENT_BRANCH_NONZERO: op_result = wide[W-1:0];
      // RULE6 RULE7 tests leave the destination alone
      `OP_TEST_BRANCH_NONZERO: op_write = 1'b0;
      `OP_TEST_BRANCH_ZERO: op_write = 1'b0;
      // outside the slice: pass the destination, no write
      default: op_write = 1'b0;
    endcase
  end

  // zero, carry, branch and instruction length per instruction
  always_comb begin
    op_zero = 1'b0;
    op_carry = 1'b0;
    op_branch = 1'b0;
    long_path = 1'b0;
    unique case (req_i.opcode)
      // RULE8 zero sum, signed overflow
      `OP_SIGNED_ADD: begin
        op_zero = (sum == '0);
        op_carry = ovf_add;
      end
      // RULE1 zero difference, signed overflow
      `OP_SIGNED_SUBTRACT: begin
        op_zero = (diff == '0);
        op_carry = ovf_sub;
      end
      // RULE2 zero only chains from the old flag
      `OP_SIGNED_ADD_WITH_CARRY: begin
        op_zero = req_i.zero_in && (sumc == '0);
        op_carry = ovf_addc;
      end
      // RULE3 zero only chains from the old flag
      `OP_SIGNED_SUBTRACT_WITH_BORROW: begin
        op_zero = req_i.zero_in && (diffc == '0);
        op_carry = ovf_subc;
      end
      // RULE4 equal operands, subtraction done
      `OP_CONDITIONAL_SUBTRACT: begin
        op_zero = d_eq_s;
        op_carry = d_ge_s;
      end
      // RULE5 loop exit runs the long count
      `OP_DECREMENT_BRANCH_NONZERO: begin
        op_zero = dec_zero;
        op_carry = dec_borrow;
        op_branch = !dec_zero;
        long_path = dec_zero;
      end
      // RULE6 carry stays clear
      `OP_TEST_BRANCH_NONZERO: begin
        op_zero = d_zero;
        op_branch = !d_zero;
        long_path = d_zero;
      end
      // RULE7 carry stays clear
      `OP_TEST_BRANCH_ZERO: begin
        op_zero = d_zero;
        op_branch = d_zero;
        long_path = !d_zero;
      end
      // outside the slice: flags pass through
      default: begin
        op_zero = req_i.zero_in;
        op_carry = req_i.carry_in;
      end
    endcase
  end

  // pack the pieces into the result carrier
  always_comb begin
    op_res.result = op_result;
    op_res.write_back = op_write;
    op_res.zero = op_zero;
    op_res.carry = op_carry;
    op_res.branch = op_branch;
    op_res.target = s[AW-1:0];
  end

  // RULE5 RULE6 RULE7 untaken branches count long
  assign cycles = long_path ? 4'(`NO_BRANCH_CLOCKS) : 4'(`NORMAL_CLOCKS);

  // hold the last result until the next taken request
  always_comb begin
    next_res = res;
    if (taken) begin
      next_res = op_res;
    end
  end

  // result register, cleared by reset
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res <= '0;
    end else begin
      res <= next_res;
    end
  end

  // RULE5 instruction time from the chosen count
  op_timer timer (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .start_i(start_i),
    .cycles_i(cycles),
    .busy_o(busy),
    .done_o(done_o)
  );

  // outputs straight from the registers and the timer
  assign busy_o = busy;
  assign res_o = res;
endmodule : arith_branch_unit

// ===== verif/dec_model.sv
// decoder side model feeding one request per go pulse
// assumes the bench raises go only at falling edges, never while busy
module dec_model (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire alu_pkg::op_req_t r_i,
  output logic start_o,
  output alu_pkg::op_req_t req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  alu_pkg::op_req_t last;
  // idle bus shows inverted data so stale copies cannot pass
  always_ff @(posedge mclk_i) if (go_i) last <= r_i;
  assign start_o = go_i;
  assign req_o = go_i ? r_i : ~last;
endmodule : dec_model

// ===== verif/abu_checker.sv
// port checker for the arithmetic and branch slice
// assumes bound to arith_branch_unit, one clock domain
module abu_checker (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire alu_pkg::op_req_t req_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire alu_pkg::op_res_t res_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // taken request and its operand views
  wire tk = start_i && !busy_o;
  wire [5:0] op = req_i.opcode;
  wire [31:0] sum = req_i.dst + req_i.src;
  wire [31:0] dif = req_i.dst - req_i.src;
  wire ge = req_i.dst >= req_i.src;
  wire dz = req_i.dst == 32'h0;
  a_add_len: assert property (tk && op == 6'h34 |=> busy_o[*3] ##1 done_o)
    else $error("add time wrong");
  a_add_sum: assert property (tk && op == 6'h34 |=> res_o.result == $past(sum))
    else $error("add sum wrong");
  a_sub_diff: assert property (tk && op == 6'h35 |=> res_o.result == $past(dif))
    else $error("difference wrong");
  a_cmp_carry: assert property (tk && op == 6'h38 |=> res_o.carry == $past(ge))
    else $error("conditional carry wrong");
  a_test_nowrite: assert property (tk && op[5:1] == 5'h1d
    |=> !res_o.write_back && !res_o.carry) else $error("test wrote back");
  a_tz_branch: assert property (tk && op == 6'h3b |=> res_o.branch == $past(dz))
    else $error("zero branch wrong");
  a_tnz_slow: assert property (tk && op == 6'h3a && dz |=> busy_o[*7] ##1 done_o)
    else $error("test no branch time wrong");
  a_decrement_branch_nonzero_slow: assert property (tk && op == 6'h39 && req_i.dst == 32'h1
    |=> busy_o[*7] ##1 done_o) else $error("loop exit time wrong");
  c_loop: cover property (tk && op == 6'h39);
  c_tz: cover property (tk && op == 6'h3b);
  c_done: cover property (done_o);
endmodule : abu_checker
bind arith_branch_unit abu_checker chk_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .start_i(start_i), .req_i(req_i), .busy_o(busy_o), .done_o(done_o),
  .res_o(res_o));

// ===== verif/signed_arith_and_loop_branch_ops_tb_top.sv
// directed bench for the arithmetic and branch slice
// assumes a 40 MHz clock and the decoder model as request source
module signed_arith_and_loop_branch_ops_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic go = 1'b0;
  logic start_i, busy_o, done_o;
  logic [3:0] nk;
  int n_mismatch = 0;
  int n_checks = 0;
  alu_pkg::op_req_t r = '0;
  alu_pkg::op_req_t req_i;
  alu_pkg::op_res_t res_o;
  always #12.5 mclk_i = ~mclk_i;
  dec_model m (.mclk_i(mclk_i), .go_i(go), .r_i(r), .start_o(start_i),
    .req_o(req_i));
  arith_branch_unit dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .start_i(start_i),
    .req_i(req_i), .busy_o(busy_o), .done_o(done_o), .res_o(res_o));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [63:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one request, then a bounded wait; nk counts cycles to done
  task automatic run(input logic [5:0] o, input logic [31:0] d, s,
    input logic [1:0] zc);
    int k;
    @(negedge mclk_i);
    r = {o, d, s, zc};
    go = 1'b1;
    @(negedge mclk_i);
    go = 1'b0;
    for (k = 0; k < 20 && done_o !== 1'b1; k++) @(negedge mclk_i);
    nk = k[3:0];
    if (k == 20) begin
      n_mismatch++;
      $display("Error t=%0t done_o %h exp %h", $time, done_o, 1'b1);
      wrap_up();
    end
  endtask : run
  task automatic t_plain();
    run(6'h34, 32'h7fffffff, 32'h1, 2'h0);
    chk({res_o[44:9], nk}, {32'h80000000, 8'ha3});
    run(6'h35, 32'h80000000, 32'h1, 2'h0);
    chk({res_o[44:9], nk}, {32'h7fffffff, 8'ha3});
    run(6'h35, 32'h5, 32'h5, 2'h0);
    chk({res_o[44:9], nk}, {32'h0, 8'hc3});
    $display("t_plain end");
  endtask : t_plain
  task automatic t_ext();
    run(6'h36, 32'hffffffff, 32'h0, 2'h3);
    chk(res_o[44:9], {32'h0, 4'hc});
    run(6'h36, 32'hffffffff, 32'h0, 2'h1);
    chk(res_o[44:9], {32'h0, 4'h8});
    run(6'h37, 32'h80000000, 32'h0, 2'h1);
    chk(res_o[44:9], {32'h7fffffff, 4'ha});
    run(6'h37, 32'h1, 32'h0, 2'h3);
    chk(res_o[44:9], {32'h0, 4'hc});
    $display("t_ext end");
  endtask : t_ext
  task automatic t_cond();
    run(6'h38, 32'h5, 32'h5, 2'h0);
    chk(res_o[44:9], {32'h0, 4'he});
    run(6'h38, 32'h3, 32'hffffffff, 2'h0);
    chk(res_o[44:9], {32'h3, 4'h8});
    $display("t_cond end");
  endtask : t_cond
  task automatic t_loop();
    run(6'h39, 32'h2, 32'h1aa, 2'h0);
    chk({res_o[44:9], nk, res_o.target}, {32'h1, 8'h93, 9'h1aa});
    run(6'h39, 32'h1, 32'h1aa, 2'h0);
    chk({res_o[44:9], nk}, {32'h0, 8'hc7});
    run(6'h39, 32'h0, 32'h1aa, 2'h0);
    chk({res_o[44:9], nk}, {32'hffffffff, 8'hb3});
    $display("t_loop end");
  endtask : t_loop
  task automatic t_test();
    run(6'h3a, 32'h0, 32'h55, 2'h1);
    chk({res_o[12:9], nk}, 8'h47);
    run(6'h3a, 32'h7, 32'h55, 2'h1);
    chk({res_o[12:9], nk, res_o.target}, {8'h13, 9'h055});
    run(6'h3b, 32'h0, 32'h55, 2'h1);
    chk({res_o[12:9], nk}, 8'h53);
    run(6'h3b, 32'h9, 32'h55, 2'h1);
    chk({res_o[12:9], nk}, 8'h07);
    $display("t_test end");
  endtask : t_test
  initial begin
    repeat (8) @(negedge mclk_i);
    nrst_i = 1'b1;
    t_plain();
    t_ext();
    t_cond();
    t_loop();
    t_test();
    wrap_up();
  end
endmodule : signed_arith_and_loop_branch_ops_tb_top
